// ### cpm_pkg.sv
package cpm_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_KHZ     = 10_000;
  localparam int T_BC_MS     = 1250;
  localparam int T_DM_MS     = 1;
  localparam int T_VGL_MS    = 40;
  localparam int T_CONT_US   = 150;
  localparam int BC_CYCLES   = T_BC_MS * CLK_KHZ;
  localparam int DM_CYCLES   = T_DM_MS * CLK_KHZ;
  localparam int VGL_CYCLES  = T_VGL_MS * CLK_KHZ;
  localparam int CONT_CYCLES = (T_CONT_US * CLK_KHZ + 999) / 1000;
  localparam int CNT_W       = 24;
  localparam int CC_W        = 11;

  // ==========================================================
  // Output levels, in 0.2 V steps from 5 V
  // ==========================================================
  localparam int STEP_W    = 7;
  localparam int V_DEF_MV  = 5000;
  localparam int V_9_MV    = 9000;
  localparam int V_12_MV   = 12000;
  localparam int V_MIN_MV  = 3600;
  localparam int STEP_MV   = 200;
  localparam int STEP_9V   = (V_9_MV - V_DEF_MV) / STEP_MV;
  localparam int STEP_12V  = (V_12_MV - V_DEF_MV) / STEP_MV;
  localparam int STEP_MIN  = (V_MIN_MV - V_DEF_MV) / STEP_MV;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam int             ADR_W          = 8;
  localparam logic [ADR_W-1:0] REG_CTRL     = 8'h00;
  localparam logic [ADR_W-1:0] REG_STATUS   = 8'h04;
  localparam logic [ADR_W-1:0] REG_FILTER   = 8'h08;
  localparam int             CTRL_HV_BIT    = 0;
  localparam int             CTRL_FORCE_BIT = 1;
  localparam logic           HV_EN_RST      = 1'h1;
  localparam logic           FORCE_RST      = 1'h0;
  localparam int             STA_STATE_LSB  = 0;
  localparam int             STA_MODE_LSB   = 2;
  localparam int             STA_SHORT_BIT  = 4;
  localparam int             STA_PD_BIT     = 5;
  localparam int             STA_UV_BIT     = 6;
  localparam int             STA_STEP_LSB   = 8;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {
    ST_SHORT   = 2'h0,
    ST_WAIT_DM = 2'h1,
    ST_ACTIVE  = 2'h3
  } cpm_state_t;

  typedef enum logic [1:0] {
    MD_DEFAULT = 2'h0,
    MD_9V      = 2'h1,
    MD_12V     = 2'h3,
    MD_CONT    = 2'h2
  } cpm_mode_t;

  typedef struct packed {
    logic dp_sel;
    logic dp_dat;
    logic dm_sel;
    logic dm_dat;
  } cpm_cmp_t;

  typedef struct packed {
    logic       up_on;
    logic       dn_on;
    logic [5:0] mag;
  } cpm_fbd_t;

  typedef struct packed {
    cpm_cmp_t                cmp_s1;
    cpm_cmp_t                cmp_s2;
    logic [1:0]              uv_s1;
    logic [1:0]              uv_s2;
    logic                    uv_hold;
    cpm_state_t              state;
    cpm_mode_t               mode;
    cpm_mode_t               vcand;
    logic                    short_sw;
    logic                    pd_sw;
    logic [CNT_W-1:0]        cnt;
    logic [CNT_W-1:0]        vcnt;
    logic [1:0]              ccand;
    logic [1:0]              cstab;
    logic [CC_W-1:0]         ccnt;
    logic signed [STEP_W-1:0] step;
    cpm_fbd_t                fbd;
    logic                    hv_en;
    logic                    force_def;
    logic                    ack;
    logic [31:0]             rdat;
  } cpm_st_t;

  localparam cpm_st_t ST_RST = '{
    state:    ST_SHORT,
    mode:     MD_DEFAULT,
    vcand:    MD_DEFAULT,
    short_sw: 1'h1,
    hv_en:    HV_EN_RST,
    force_def: FORCE_RST,
    default:  '0
  };

endpackage

// ### cpm_port_ctrl.sv
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/10ps
module cpm_port_ctrl
  import cpm_pkg::*;
#(
  parameter int BC_CYC  = BC_CYCLES,
  parameter int DM_CYC  = DM_CYCLES,
  parameter int VGL_CYC = VGL_CYCLES
)(
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire cpm_cmp_t         dl_cmp,
  input  wire logic             bp_below_reset,
  input  wire logic             bp_above_run,
  input  wire logic             wb_cyc,
  input  wire logic             wb_stb,
  input  wire logic             wb_we,
  input  wire logic [ADR_W-1:0] wb_adr,
  input  wire logic [3:0]       wb_sel,
  input  wire logic [31:0]      wb_wdat,
  output logic [31:0]           wb_rdat,
  output logic                  wb_ack,
  output logic                  data_line_short_switch,
  output logic                  dminus_pulldown_switch,
  output cpm_fbd_t              feedback_drive_output,
  output cpm_mode_t             port_mode
);

  // ==========================================================
  // Elaboration checks
  // ==========================================================
  // Filter counters cnt and vcnt are CNT_W wide; longer filters would wrap
  if (BC_CYC < 1 || BC_CYC >= (1 << CNT_W))
  begin : g_chk_bc
    $error("BC_CYC out of range");
  end
  if (DM_CYC < 1 || DM_CYC >= (1 << CNT_W))
  begin : g_chk_dm
    $error("DM_CYC out of range");
  end
  if (VGL_CYC < 1 || VGL_CYC >= (1 << CNT_W))
  begin : g_chk_vgl
    $error("VGL_CYC out of range");
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  // Maps comparator levels to {valid, mode}
  function automatic logic [2:0] decode(input cpm_cmp_t c);
    logic dp_hi;
    logic dp_mid;
    logic dm_hi;
    logic dm_mid;
    logic dm_gnd;
    dp_hi  = c.dp_sel;
    dp_mid = c.dp_dat & ~c.dp_sel;
    dm_hi  = c.dm_sel;
    dm_mid = c.dm_dat & ~c.dm_sel;
    dm_gnd = ~c.dm_dat;
    if (dp_mid && dm_mid)
      decode = {1'h1, MD_12V};
    else if (dp_hi && dm_mid)
      decode = {1'h1, MD_9V};
    else if (dp_mid && dm_hi)
      decode = {1'h1, MD_CONT};
    else if (dp_mid && dm_gnd)
      decode = {1'h1, MD_DEFAULT};
    else
      decode = {1'h0, MD_DEFAULT};
  endfunction

  // Fixed step level for a mode
  function automatic logic [STEP_W-1:0] level(input cpm_mode_t m);
    unique case (m)
      MD_12V:  level = STEP_W'(STEP_12V);
      MD_9V:   level = STEP_W'(STEP_9V);
      default: level = '0;
    endcase
  endfunction

  // Back to default: short on, pull-down off, 5 V
  function automatic cpm_st_t to_default(input cpm_st_t s);
    cpm_st_t r;
    r          = s;
    r.state    = ST_SHORT;
    r.mode     = MD_DEFAULT;
    r.vcand    = MD_DEFAULT;
    r.short_sw = 1'h1;
    r.pd_sw    = 1'h0;
    r.step     = '0;
    r.cnt      = '0;
    r.vcnt     = '0;
    r.ccnt     = '0;
    r.ccand    = '0;
    r.cstab    = '0;
    to_default = r;
  endfunction

  // ==========================================================
  // State
  // ==========================================================
  cpm_st_t            st_r;
  cpm_st_t            st_nxt;
  cpm_cmp_t           cmp;
  logic [2:0]         dec;
  logic [1:0]         craw;
  logic [STEP_W-1:0]  magv;
  logic               wb_hit;

  // Next-state logic, one pass over the whole block
  always_comb
  begin
    st_nxt = st_r;
    cmp    = st_r.cmp_s2;
    dec    = decode(st_r.cmp_s2);
    craw   = '0;
    magv   = '0;
    wb_hit = wb_cyc & wb_stb & ~st_r.ack;

    // Two-stage synchronisers; only stage two is read
    st_nxt.cmp_s1 = dl_cmp;
    st_nxt.cmp_s2 = st_r.cmp_s1;
    st_nxt.uv_s1  = {bp_below_reset, bp_above_run};
    st_nxt.uv_s2  = st_r.uv_s1;

    // Hysteresis: trip low, release only at the run level
    if (st_r.uv_s2[1])
      st_nxt.uv_hold = 1'h1;
    else if (st_r.uv_s2[0])
      st_nxt.uv_hold = 1'h0;

    unique case (st_r.state)
      ST_SHORT:
      begin
        // Lines joined, no adjustment until capability is seen
        st_nxt.short_sw = 1'h1;
        st_nxt.pd_sw    = 1'h0;
        st_nxt.mode     = MD_DEFAULT;
        st_nxt.step     = '0;
        if (cmp.dp_dat && st_r.hv_en)
        begin
          if (st_r.cnt >= CNT_W'(BC_CYC - 1))
          begin
            st_nxt.state    = ST_WAIT_DM;
            st_nxt.short_sw = 1'h0;
            st_nxt.cnt      = '0;
          end
          else
            st_nxt.cnt = st_r.cnt + CNT_W'(1);
        end
        else
          st_nxt.cnt = '0;
      end
      ST_WAIT_DM:
      begin
        // Device releases D- once its handshakes are done in order
        if (!cmp.dm_dat)
        begin
          if (st_r.cnt >= CNT_W'(DM_CYC - 1))
          begin
            st_nxt.state = ST_ACTIVE;
            st_nxt.pd_sw = 1'h1;
            st_nxt.cnt   = '0;
            st_nxt.vcand = MD_DEFAULT;
            st_nxt.vcnt  = '0;
          end
          else
            st_nxt.cnt = st_r.cnt + CNT_W'(1);
        end
        else
          st_nxt.cnt = '0;
      end
      ST_ACTIVE:
      begin
        // Invalid combinations hold the candidate, so D+ high pulses in continuous
        // mode never flip the mode; a D- mid pulse decodes as 12 V and flips it if held VGL_CYC
        if (dec[2])
        begin
          if (cpm_mode_t'(dec[1:0]) != st_r.vcand)
          begin
            st_nxt.vcand = cpm_mode_t'(dec[1:0]);
            st_nxt.vcnt  = '0;
          end
          else if (st_r.vcnt < CNT_W'(VGL_CYC - 1))
            st_nxt.vcnt = st_r.vcnt + CNT_W'(1);
          else if (st_r.mode != st_r.vcand)
          begin
            st_nxt.mode  = st_r.vcand;
            st_nxt.ccand = '0;
            st_nxt.cstab = '0;
            st_nxt.ccnt  = '0;
            if (st_r.vcand != MD_CONT)
              st_nxt.step = level(st_r.vcand);
          end
        end

        // Continuous mode: filtered D+ high steps up, D- mid down
        if (st_r.mode == MD_CONT)
        begin
          craw = {cmp.dp_sel, cmp.dm_dat & ~cmp.dm_sel};
          if (craw != st_r.ccand)
          begin
            st_nxt.ccand = craw;
            st_nxt.ccnt  = '0;
          end
          else if (st_r.ccnt < CC_W'(CONT_CYCLES - 1))
            st_nxt.ccnt = st_r.ccnt + CC_W'(1);
          else
          begin
            st_nxt.cstab = st_r.ccand;
            if (st_r.ccand[1] && !st_r.cstab[1]
                && st_r.step < $signed(STEP_W'(STEP_12V)))
              st_nxt.step = st_r.step + STEP_W'(1);
            if (st_r.ccand[0] && !st_r.cstab[0]
                && st_r.step > $signed(STEP_W'(STEP_MIN)))
              st_nxt.step = st_r.step - STEP_W'(1);
          end
        end
      end
      default:
        st_nxt = to_default(st_r);
    endcase

    // Unplug, software override and undervoltage all force default
    if (!cmp.dp_dat && st_r.state != ST_SHORT)
      st_nxt = to_default(st_nxt);
    if (st_r.force_def)
      st_nxt = to_default(st_nxt);
    if (st_r.uv_hold)
      st_nxt = to_default(st_nxt);

    // Current drive from step level; zero step means both off
    magv = st_nxt.step[STEP_W-1] ? (~st_nxt.step + STEP_W'(1))
                                 : st_nxt.step;
    st_nxt.fbd.up_on = !st_nxt.step[STEP_W-1]
                       && (st_nxt.step != '0);
    st_nxt.fbd.dn_on = st_nxt.step[STEP_W-1];
    st_nxt.fbd.mag   = magv[5:0];

    // Wishbone: ack one cycle after request; write at the ack edge
    st_nxt.ack  = wb_hit;
    st_nxt.rdat = '0;
    if (wb_hit && !wb_we)
    begin
      if (wb_adr[ADR_W-1:2] == REG_CTRL[ADR_W-1:2])
      begin
        st_nxt.rdat[CTRL_HV_BIT]    = st_r.hv_en;
        st_nxt.rdat[CTRL_FORCE_BIT] = st_r.force_def;
      end
      else if (wb_adr[ADR_W-1:2] == REG_STATUS[ADR_W-1:2])
      begin
        st_nxt.rdat[STA_STATE_LSB +: 2] = st_r.state;
        st_nxt.rdat[STA_MODE_LSB +: 2]  = st_r.mode;
        st_nxt.rdat[STA_SHORT_BIT]      = st_r.short_sw;
        st_nxt.rdat[STA_PD_BIT]         = st_r.pd_sw;
        st_nxt.rdat[STA_UV_BIT]         = st_r.uv_hold;
        st_nxt.rdat[STA_STEP_LSB +: 8]  = {st_r.step[STEP_W-1], st_r.step};
      end
      else if (wb_adr[ADR_W-1:2] == REG_FILTER[ADR_W-1:2])
        st_nxt.rdat[CNT_W-1:0] = st_r.vcnt;
    end
    if (st_r.ack && wb_cyc && wb_stb && wb_we && wb_sel[0]
        && wb_adr[ADR_W-1:2] == REG_CTRL[ADR_W-1:2])
    begin
      st_nxt.hv_en     = wb_wdat[CTRL_HV_BIT];
      st_nxt.force_def = wb_wdat[CTRL_FORCE_BIT];
    end
  end

  // Single state register
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      st_r <= ST_RST;
    else
      st_r <= st_nxt;
  end

  // ==========================================================
  // Outputs, straight from the state register
  // ==========================================================
  assign wb_rdat                = st_r.rdat;
  assign wb_ack                 = st_r.ack;
  assign data_line_short_switch = st_r.short_sw;
  assign dminus_pulldown_switch = st_r.pd_sw;
  assign feedback_drive_output  = st_r.fbd;
  assign port_mode              = st_r.mode;

endmodule

// ### cpm_port_monitor.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker
module cpm_port_monitor
  import cpm_pkg::*;
#(
  parameter int BC_CYC  = BC_CYCLES,
  parameter int DM_CYC  = DM_CYCLES,
  parameter int VGL_CYC = VGL_CYCLES
)(
  input wire logic             sys_clk,
  input wire logic             reset,
  input wire cpm_cmp_t         dl_cmp,
  input wire logic             bp_below_reset,
  input wire logic             bp_above_run,
  input wire logic             wb_cyc,
  input wire logic             wb_stb,
  input wire logic             wb_we,
  input wire logic [ADR_W-1:0] wb_adr,
  input wire logic [3:0]       wb_sel,
  input wire logic [31:0]      wb_wdat,
  input wire logic [31:0]      wb_rdat,
  input wire logic             wb_ack,
  input wire logic             data_line_short_switch,
  input wire logic             dminus_pulldown_switch,
  input wire cpm_fbd_t         feedback_drive_output,
  input wire cpm_mode_t        port_mode
);
  logic [31:0] hi_cnt;
  logic [31:0] lo_cnt;
  logic [31:0] st_cnt;
  cpm_cmp_t    prev;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Run lengths of line levels; cleared by reset so no unknown lingers
  always_ff @(posedge sys_clk)
  begin
    hi_cnt <= (reset || !dl_cmp.dp_dat) ? '0 : hi_cnt + 1;
    lo_cnt <= (reset || dl_cmp.dm_dat) ? '0 : lo_cnt + 1;
    st_cnt <= (reset || dl_cmp != prev) ? '0 : st_cnt + 1;
    prev   <= dl_cmp;
  end

  sequence s_default;
    data_line_short_switch && !dminus_pulldown_switch && port_mode == MD_DEFAULT;
  endsequence
  sequence s_unplug;
    !dl_cmp.dp_dat [*3];
  endsequence

  a_reset_state: assert property (disable iff (1'b0) reset |=> s_default ##0 !wb_ack)
    else $error("reset state wrong");
  a_pd_open: assert property (dminus_pulldown_switch |-> !data_line_short_switch)
    else $error("pull-down with short closed");
  a_open_filter: assert property ($fell(data_line_short_switch) |-> hi_cnt >= BC_CYC)
    else $error("short opened too early");
  a_pd_filter: assert property ($rose(dminus_pulldown_switch) |-> lo_cnt >= DM_CYC)
    else $error("pull-down closed too early");
  a_mode_filter: assert property ($changed(port_mode) && port_mode != MD_DEFAULT
    |-> st_cnt >= VGL_CYC)
    else $error("mode changed before filter time");
  a_fbd_12v: assert property (port_mode == MD_12V [*2]
    |-> feedback_drive_output == cpm_fbd_t'{1'b1, 1'b0, 6'(STEP_12V)})
    else $error("wrong drive in 12 V mode");
  a_fbd_9v: assert property (port_mode == MD_9V [*2]
    |-> feedback_drive_output == cpm_fbd_t'{1'b1, 1'b0, 6'(STEP_9V)})
    else $error("wrong drive in 9 V mode");
  a_fbd_default: assert property (port_mode == MD_DEFAULT [*2]
    |-> feedback_drive_output == '0)
    else $error("drive active in default mode");
  a_unplug_default: assert property (s_unplug |=> s_default)
    else $error("unplug did not restore default");
  a_uv_default: assert property (bp_below_reset [*5] |=> s_default)
    else $error("undervoltage did not restore default");
  a_ack_pulse: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack ##1 !wb_ack)
    else $error("bus answer not a one-cycle pulse");
endmodule

bind cpm_port_ctrl cpm_port_monitor #(.BC_CYC(BC_CYC), .DM_CYC(DM_CYC), .VGL_CYC(VGL_CYC))
  i_cpm_port_monitor (.sys_clk(sys_clk), .reset(reset), .dl_cmp(dl_cmp),
  .bp_below_reset(bp_below_reset), .bp_above_run(bp_above_run), .wb_cyc(wb_cyc),
  .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdat(wb_wdat),
  .wb_rdat(wb_rdat), .wb_ack(wb_ack), .data_line_short_switch(data_line_short_switch),
  .dminus_pulldown_switch(dminus_pulldown_switch),
  .feedback_drive_output(feedback_drive_output), .port_mode(port_mode));

// ### cpm_dev_model.sv
`timescale 1ns/10ps
// ==========================================================
// Portable device: line levels 0 GND, 1 about 0.6 V, 2 about 3.3 V
module cpm_dev_model
  import cpm_pkg::*;
(
  input  wire logic [1:0] dp_lvl,
  input  wire logic [1:0] dm_lvl,
  output cpm_cmp_t        dl_cmp
);
  // Levels change only when the bench moves them, after a clock edge
  assign dl_cmp = '{dp_sel: dp_lvl[1], dp_dat: |dp_lvl, dm_sel: dm_lvl[1], dm_dat: |dm_lvl};
endmodule

// ### charger_port_mode_controller_test.sv
`timescale 1ns/10ps
// ==========================================================
// Bench
module charger_port_mode_controller_test
  import cpm_pkg::*;
;
  typedef struct packed {
    logic [1:0] dp;
    logic [1:0] dm;
    cpm_mode_t  md;
    cpm_fbd_t   fb;
  } cpm_row_t;

  localparam int BC = 20;
  localparam int DM = 5;
  localparam int VG = 10;
  localparam cpm_fbd_t F9 = '{1'b1, 1'b0, 6'(STEP_9V)};
  localparam cpm_row_t ROWS [4] = '{
    '{2'h1, 2'h1, MD_12V, cpm_fbd_t'{1'b1, 1'b0, 6'(STEP_12V)}},
    '{2'h1, 2'h0, MD_DEFAULT, cpm_fbd_t'(8'h00)},
    '{2'h2, 2'h1, MD_9V, F9},
    '{2'h1, 2'h2, MD_CONT, F9}};

  logic        sys_clk, reset, bp_below_reset, bp_above_run;
  logic        wb_cyc, wb_stb, wb_we, wb_ack, sw_short, sw_pd;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat, wb_rdat, rd;
  logic [1:0]  dp_lvl, dm_lvl;
  cpm_cmp_t    dl_cmp;
  cpm_fbd_t    fbd;
  cpm_mode_t   port_mode;
  int          n_fail, comparisons;

  cpm_dev_model i_cpm_dev_model (.dp_lvl(dp_lvl), .dm_lvl(dm_lvl), .dl_cmp(dl_cmp));
  cpm_port_ctrl #(.BC_CYC(BC), .DM_CYC(DM), .VGL_CYC(VG)) i_cpm_port_ctrl (
    .sys_clk(sys_clk), .reset(reset), .dl_cmp(dl_cmp), .bp_below_reset(bp_below_reset),
    .bp_above_run(bp_above_run), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdat(wb_wdat), .wb_rdat(wb_rdat),
    .wb_ack(wb_ack), .data_line_short_switch(sw_short), .dminus_pulldown_switch(sw_pd),
    .feedback_drive_output(fbd), .port_mode(port_mode));

  // Clock, 100 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One classic cycle; waits for ack however long it takes
  task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    @(posedge sys_clk);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_sel  <= 4'hF;
    wb_adr  <= adr;
    wb_wdat <= wd;
    do @(posedge sys_clk); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic lines(input logic [1:0] p, input logic [1:0] m);
    dp_lvl <= p;
    dm_lvl <= m;
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence: reset checks first, then rows, unplug, undervoltage, override and legacy cases
  initial
  begin
    {reset, bp_above_run, wb_sel} <= 6'h3F;
    {bp_below_reset, wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} <= '0;
    lines(2'h0, 2'h0);
    idle(10);
    reset <= 1'b0;
    idle(2);
    check({sw_short, sw_pd, port_mode, fbd}, 12'h800);
    wb_io(1'b0, REG_CTRL, '0);
    check(rd, {30'h0, FORCE_RST, HV_EN_RST});
    wb_io(1'b0, 8'h0C, '0);
    check(rd, '0);
    $display("reset test done");
    lines(2'h1, 2'h1);
    idle(BC + 6);
    check(sw_short, 1'b0);
    // Device finishes its handshakes in order, D- pulled low last
    lines(2'h1, 2'h0);
    idle(DM + 6);
    check(sw_pd, 1'b1);
    foreach (ROWS[i])
    begin
      lines(ROWS[i].dp, ROWS[i].dm);
      idle(VG + 8);
      check({port_mode, fbd}, {ROWS[i].md, ROWS[i].fb});
    end
    $display("mode table done");
    // Continuous mode: one filtered D+ rise gives exactly one step up
    lines(2'h2, 2'h2);
    idle(2 * CONT_CYCLES + 20);
    check({port_mode, fbd}, {MD_CONT, 1'b1, 1'b0, 6'(STEP_9V + 1)});
    lines(2'h0, 2'h2);
    idle(6);
    check({sw_short, sw_pd, port_mode, fbd}, 12'h800);
    $display("unplug test done");
    lines(2'h1, 2'h1);
    idle(BC + 6);
    {bp_below_reset, bp_above_run} <= 2'h2;
    idle(BC + 10);
    check({sw_short, sw_pd}, 2'h2);
    bp_below_reset <= 1'b0;
    idle(BC + 10);
    check(sw_short, 1'b1);
    bp_above_run <= 1'b1;
    idle(BC + 10);
    check(sw_short, 1'b0);
    $display("undervoltage test done");
    // Software override pulls a running port back to default
    wb_io(1'b1, REG_CTRL, 32'h3);
    idle(3);
    check({sw_short, sw_pd, port_mode, fbd}, 12'h800);
    wb_io(1'b0, REG_CTRL, '0);
    check(rd, 32'h3);
    wb_io(1'b1, REG_CTRL, 32'h1);
    $display("override test done");
    // Legacy device drops D+ before the capability filter runs out
    lines(2'h0, 2'h0);
    idle(6);
    lines(2'h1, 2'h1);
    idle(BC - 5);
    lines(2'h0, 2'h0);
    idle(6);
    check({sw_short, port_mode, fbd}, 11'h400);
    wb_io(1'b1, REG_CTRL, '0);
    wb_io(1'b0, REG_CTRL, '0);
    check(rd, '0);
    lines(2'h0, 2'h0);
    idle(6);
    lines(2'h1, 2'h1);
    idle(BC + 10);
    check({sw_short, port_mode, fbd}, 11'h400);
    $display("legacy test done");
    wb_io(1'b0, REG_STATUS, '0);
    check(rd, 32'h1 << STA_SHORT_BIT);
    wb_io(1'b0, REG_FILTER, '0);
    check(rd, '0);
    $display("status test done");
    // Mid-run reset brings back the power-up state and register values
    reset <= 1'b1;
    idle(2);
    reset <= 1'b0;
    idle(2);
    check({sw_short, sw_pd, port_mode, fbd}, 12'h800);
    wb_io(1'b0, REG_CTRL, '0);
    check(rd, {30'h0, FORCE_RST, HV_EN_RST});
    $display("mid-run reset test done");
    print_verdict();
  end

  // Watchdog well beyond the expected run of about 3400 cycles
  initial
  begin
    idle(20000);
    n_fail++;
    $display("mismatch at %0t: run timed out", $time);
    print_verdict();
  end
endmodule
